// [ls_timing.v]
// Measurement timing and low-limit interrupt logic of the light sensor
`timescale 1ns/1ps
`include "ls_defs.vh"
module ls_timing #(
  parameter DW = 24,
  parameter PW = 4
) (
  input  wire          CORE_CLK,
  input  wire          RST_B,
  input  wire [7:0]    REG_ADDR,
  input  wire [7:0]    REG_WDATA,
  input  wire          REG_WR,
  input  wire          REG_RD,
  output reg  [7:0]    REG_RDATA,
  input  wire          MEAS_ENABLE,
  input  wire          FLICKER_ENABLE,
  input  wire [2:0]    MODULATOR_CLOCK_DIVIDER,
  input  wire [7:0]    TRIGGER_TIMING_UNIT,
  input  wire          LIMIT_CHANNEL_SELECT,
  input  wire [PW-1:0] PERSISTENCE_COUNT,
  input  wire          LIGHT_IRQ_ENABLE,
  input  wire          LIGHT_IRQ_FLAG_CLEAR,
  input  wire          SAMPLE_VALID,
  input  wire [DW-1:0] CHANNEL0_DATA,
  input  wire [DW-1:0] CHANNEL1_DATA,
  output reg           STEP_TICK,
  output reg           MEAS_BUSY,
  output reg           LIGHT_MEAS_DONE,
  output reg           FLICKER_STEP_DONE,
  output reg           FLICKER_END_MARK,
  output reg           IRQ_PIN,
  output reg           LIGHT_IRQ_FLAG,
  output reg           LIGHT_LOW_IRQ_FLAG
);
  localparam integer MOD_CYC = `LS_MOD_PERIOD_PS / `LS_CLK_PERIOD_PS;
  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_MEAS  = 2'd1;
  localparam [1:0] ST_PAUSE = 2'd2;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0] step_lo_q, step_hi_q, lcnt_lo_q, lcnt_hi_q;
  reg [7:0] fcnt_lo_q, fcnt_hi_q, pause_q, lim0_q, lim1_q, lim2_q;

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      step_lo_q <= `LS_RST_STEP_LO;
      step_hi_q <= `LS_RST_ZERO;
      lcnt_lo_q <= `LS_RST_ZERO;
      lcnt_hi_q <= `LS_RST_ZERO;
      fcnt_lo_q <= `LS_RST_ZERO;
      fcnt_hi_q <= `LS_RST_ZERO;
      pause_q   <= `LS_RST_ZERO;
      lim0_q    <= `LS_RST_ZERO;
      lim1_q    <= `LS_RST_ZERO;
      lim2_q    <= `LS_RST_ZERO;
    end else if (REG_WR) begin
      case (REG_ADDR)
        `LS_ADDR_STEP_LO: step_lo_q <= REG_WDATA;
        `LS_ADDR_STEP_HI: step_hi_q <= REG_WDATA & `LS_HI_MASK;
        `LS_ADDR_LCNT_LO: lcnt_lo_q <= REG_WDATA;
        `LS_ADDR_LCNT_HI: lcnt_hi_q <= REG_WDATA & `LS_HI_MASK;
        `LS_ADDR_FCNT_LO: fcnt_lo_q <= REG_WDATA;
        `LS_ADDR_FCNT_HI: fcnt_hi_q <= REG_WDATA & `LS_FCNT_HI_MASK;
        `LS_ADDR_PAUSE:   pause_q   <= REG_WDATA;
        `LS_ADDR_LIM0:    lim0_q    <= REG_WDATA;
        `LS_ADDR_LIM1:    lim1_q    <= REG_WDATA;
        `LS_ADDR_LIM2:    lim2_q    <= REG_WDATA;
        default: ;
      endcase
    end
  end

  reg [7:0] rd_d;
  always @* begin
    case (REG_ADDR)
      `LS_ADDR_STEP_LO: rd_d = step_lo_q;
      `LS_ADDR_STEP_HI: rd_d = step_hi_q;
      `LS_ADDR_LCNT_LO: rd_d = lcnt_lo_q;
      `LS_ADDR_LCNT_HI: rd_d = lcnt_hi_q;
      `LS_ADDR_FCNT_LO: rd_d = fcnt_lo_q;
      `LS_ADDR_FCNT_HI: rd_d = fcnt_hi_q;
      `LS_ADDR_PAUSE:   rd_d = pause_q;
      `LS_ADDR_LIM0:    rd_d = lim0_q;
      `LS_ADDR_LIM1:    rd_d = lim1_q;
      `LS_ADDR_LIM2:    rd_d = lim2_q;
      default:          rd_d = `LS_RST_ZERO;
    endcase
  end

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B)
      REG_RDATA <= `LS_RST_ZERO;
    else if (REG_RD)
      REG_RDATA <= rd_d;
  end

  wire [10:0] step_count   = {step_hi_q[2:0], step_lo_q};
  wire [10:0] light_count  = {lcnt_hi_q[2:0], lcnt_lo_q};
  wire [10:0] flicker_count = {fcnt_hi_q[2:0], fcnt_lo_q};
  wire        endless      = fcnt_hi_q[`LS_ENDLESS_BIT];
  wire [23:0] low_limit    = {lim2_q, lim1_q, lim0_q};

  ////////////////////////////////////////////////////////////////////////////
  // Modulator clock
  reg  [7:0] pre_q;
  reg  [6:0] div_q;
  reg        mod_tick_q;
  reg  [1:0] state_q;
  reg        flk_run_q;
  wire       timing_on = (state_q != ST_IDLE) || flk_run_q;
  wire       pre_wrap  = (pre_q == MOD_CYC[7:0] - 8'h01);
  // divider by two to the select
  // Compare with >= so a smaller divider taken mid-count cannot stall the tick
  wire       div_wrap  = (div_q >= ((7'h01 << MODULATOR_CLOCK_DIVIDER) - 7'h01));

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pre_q      <= 8'h00;
      div_q      <= 7'h00;
      mod_tick_q <= 1'b0;
    end else if (!timing_on) begin
      pre_q      <= 8'h00;
      div_q      <= 7'h00;
      mod_tick_q <= 1'b0;
    end else begin
      pre_q      <= pre_wrap ? 8'h00 : pre_q + 8'h01;
      mod_tick_q <= pre_wrap && div_wrap;
      if (pre_wrap)
        div_q <= div_wrap ? 7'h00 : div_q + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Step, light and flicker sequencing
  wire step_done;
  wire light_done;
  wire flk_done;
  wire in_meas  = (state_q == ST_MEAS);
  wire start    = (state_q == ST_IDLE) && MEAS_ENABLE;

  // step of count plus one ticks
  ls_cnt #(.W(11)) u_step (
    .clk    (CORE_CLK),
    .rst_b  (RST_B),
    .clr    (!timing_on || state_q == ST_PAUSE),
    .inc    (mod_tick_q),
    .limit  (step_count),
    .done_q (step_done)
  );

  ls_cnt #(.W(11)) u_light (
    .clk    (CORE_CLK),
    .rst_b  (RST_B),
    .clr    (!in_meas),
    .inc    (step_done && in_meas),
    .limit  (light_count),
    .done_q (light_done)
  );

  ls_cnt #(.W(11)) u_flicker (
    .clk    (CORE_CLK),
    .rst_b  (RST_B),
    .clr    (!flk_run_q),
    .inc    (step_done && flk_run_q),
    .limit  (flicker_count),
    .done_q (flk_done)
  );

  // Pause counted in modulator ticks; 16 bits holds the full product
  reg  [15:0] pause_cnt_q;
  wire [15:0] pause_len = TRIGGER_TIMING_UNIT * pause_q;

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_q     <= ST_IDLE;
      pause_cnt_q <= 16'h0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          pause_cnt_q <= 16'h0000;
          if (MEAS_ENABLE)
            state_q <= ST_MEAS;
        end
        ST_MEAS: begin
          pause_cnt_q <= 16'h0000;
          if (!MEAS_ENABLE)
            state_q <= ST_IDLE;
          else if (light_done && pause_len != 16'h0000)
            state_q <= ST_PAUSE;
        end
        ST_PAUSE: begin
          if (!MEAS_ENABLE)
            state_q <= ST_IDLE;
          else if (pause_cnt_q >= pause_len)
            state_q <= ST_MEAS;
          else if (mod_tick_q)
            pause_cnt_q <= pause_cnt_q + 16'h0001;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      flk_run_q         <= 1'b0;
      FLICKER_STEP_DONE <= 1'b0;
      FLICKER_END_MARK  <= 1'b0;
      LIGHT_MEAS_DONE   <= 1'b0;
      STEP_TICK         <= 1'b0;
      MEAS_BUSY         <= 1'b0;
    end else begin
      if (!FLICKER_ENABLE)
        flk_run_q <= 1'b0;
      else if (start)
        flk_run_q <= 1'b1;
      else if (flk_done && !endless)
        flk_run_q <= 1'b0;
      FLICKER_STEP_DONE <= flk_done;
      FLICKER_END_MARK  <= flk_done && !endless;
      LIGHT_MEAS_DONE   <= light_done;
      STEP_TICK         <= step_done;
      MEAS_BUSY         <= timing_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-limit detection
  // selected channel against limit
  wire [DW-1:0] sel_data = LIMIT_CHANNEL_SELECT ? CHANNEL1_DATA : CHANNEL0_DATA;
  wire          below    = sel_data < low_limit;
  reg  [PW-1:0] pers_q;
  wire [PW-1:0] pers_next = pers_q + {{(PW-1){1'b0}}, 1'b1};
  // A persistence of zero fires on every low sample
  wire          fire = SAMPLE_VALID && below && LIGHT_IRQ_ENABLE &&
                       (pers_next >= PERSISTENCE_COUNT || pers_q == {PW{1'b1}});

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B)
      pers_q <= {PW{1'b0}};
    else if (SAMPLE_VALID) begin
      if (!below)
        pers_q <= {PW{1'b0}};
      else if (pers_q != {PW{1'b1}})
        pers_q <= pers_next;
    end
  end

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      LIGHT_IRQ_FLAG     <= 1'b0;
      LIGHT_LOW_IRQ_FLAG <= 1'b0;
      IRQ_PIN            <= 1'b0;
    end else begin
      // set on persistent low; set beats clear
      LIGHT_IRQ_FLAG     <= fire | (LIGHT_IRQ_FLAG & ~LIGHT_IRQ_FLAG_CLEAR);
      LIGHT_LOW_IRQ_FLAG <= fire | (LIGHT_LOW_IRQ_FLAG & ~LIGHT_IRQ_FLAG_CLEAR);
      IRQ_PIN            <= fire | (IRQ_PIN & ~LIGHT_IRQ_FLAG_CLEAR);
    end
  end
endmodule // ls_timing

// [ls_defs.vh]
// Register map, reset values and timing constants of the light timing block
`ifndef LS_DEFS_VH
`define LS_DEFS_VH
`define LS_ADDR_STEP_LO    8'h83
`define LS_ADDR_STEP_HI    8'h84
`define LS_ADDR_LCNT_LO    8'h85
`define LS_ADDR_LCNT_HI    8'h86
`define LS_ADDR_FCNT_LO    8'h87
`define LS_ADDR_FCNT_HI    8'h88
`define LS_ADDR_PAUSE      8'h89
`define LS_ADDR_LIM0       8'h8a
`define LS_ADDR_LIM1       8'h8b
`define LS_ADDR_LIM2       8'h8c
`define LS_RST_STEP_LO     8'hb3
`define LS_RST_ZERO        8'h00
`define LS_HI_MASK         8'h07
`define LS_FCNT_HI_MASK    8'h87
`define LS_ENDLESS_BIT     7
`define LS_MOD_PERIOD_PS   1388889
`define LS_CLK_PERIOD_PS   10000
`endif

// [ls_cnt.v]
// Wrapping event counter with a registered terminal pulse
`timescale 1ns/1ps
module ls_cnt #(
  parameter W = 11
) (
  input  wire         clk,
  input  wire         rst_b,
  input  wire         clr,
  input  wire         inc,
  input  wire [W-1:0] limit,
  output reg          done_q
);
  reg [W-1:0] count_q;
  wire        hit = inc && (count_q == limit);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= {W{1'b0}};
      done_q  <= 1'b0;
    end else begin
      done_q <= hit && !clr;
      if (clr || hit)
        count_q <= {W{1'b0}};
      else if (inc)
        count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // ls_cnt

// [ls_host.sv]
// Host model driving the register port
`timescale 1ns/1ps
module ls_host (
  input  wire       CORE_CLK,
  input  wire [7:0] REG_RDATA,
  output reg  [7:0] REG_ADDR,
  output reg  [7:0] REG_WDATA,
  output reg        REG_WR,
  output reg        REG_RD
);
  initial begin
    {REG_ADDR, REG_WDATA, REG_WR, REG_RD} = 18'h0;
  end
  // Released lines show the inverse, never a stale match
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge CORE_CLK);
      {REG_ADDR, REG_WDATA, REG_WR} = {a, d, 1'b1};
      @(negedge CORE_CLK);
      {REG_ADDR, REG_WDATA, REG_WR} = {~a, ~d, 1'b0};
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(negedge CORE_CLK);
      {REG_ADDR, REG_RD} = {a, 1'b1};
      @(negedge CORE_CLK);
      {REG_ADDR, REG_RD} = {~a, 1'b0};
      @(negedge CORE_CLK);
      d = REG_RDATA;
    end
  endtask
endmodule // ls_host

// [ls_timing_sva.sv]
// Port assertions of the light timing block
`timescale 1ns/1ps
module ls_timing_sva (
  input wire       CORE_CLK,
  input wire       RST_B,
  input wire [7:0] REG_ADDR,
  input wire       REG_RD,
  input wire [7:0] REG_RDATA,
  input wire       LIGHT_IRQ_ENABLE,
  input wire       LIGHT_IRQ_FLAG_CLEAR,
  input wire       SAMPLE_VALID,
  input wire       STEP_TICK,
  input wire       LIGHT_MEAS_DONE,
  input wire       FLICKER_STEP_DONE,
  input wire       FLICKER_END_MARK,
  input wire       IRQ_PIN,
  input wire       LIGHT_IRQ_FLAG,
  input wire       LIGHT_LOW_IRQ_FLAG
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  a_step_hi_mask: assert property (REG_RD && REG_ADDR == 8'h84 |=> REG_RDATA[7:3] == 5'h0)
    else $error("upper step bits not zero");
  a_flk_hi_mask: assert property (REG_RD && REG_ADDR == 8'h88 |=> REG_RDATA[6:3] == 4'h0)
    else $error("flicker reserved bits not zero");
  a_irq_sticky: assert property (IRQ_PIN && !LIGHT_IRQ_FLAG_CLEAR |=> IRQ_PIN)
    else $error("interrupt dropped without clear");
  a_clear_all: assert property (LIGHT_IRQ_FLAG_CLEAR && !SAMPLE_VALID |=>
    !IRQ_PIN && !LIGHT_IRQ_FLAG && !LIGHT_LOW_IRQ_FLAG) else $error("clear left a flag");
  a_flags_agree: assert property (IRQ_PIN == LIGHT_IRQ_FLAG && IRQ_PIN == LIGHT_LOW_IRQ_FLAG)
    else $error("pin and flags disagree");
  a_irq_cause: assert property ($rose(IRQ_PIN) |-> $past(SAMPLE_VALID && LIGHT_IRQ_ENABLE))
    else $error("interrupt without enabled sample");
  a_mark_done: assert property (FLICKER_END_MARK |-> FLICKER_STEP_DONE)
    else $error("end mark outside sequence end");
  a_done_tick: assert property (LIGHT_MEAS_DONE |-> $past(STEP_TICK))
    else $error("light done not after a step");
  a_tick_pulse: assert property (STEP_TICK |=> !STEP_TICK)
    else $error("step tick too long");
  c_irq: cover property ($rose(IRQ_PIN));
  c_done: cover property (LIGHT_MEAS_DONE);
  c_mark: cover property (FLICKER_END_MARK);
endmodule // ls_timing_sva
bind ls_timing ls_timing_sva u_sva (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .LIGHT_IRQ_ENABLE(LIGHT_IRQ_ENABLE),
  .LIGHT_IRQ_FLAG_CLEAR(LIGHT_IRQ_FLAG_CLEAR), .SAMPLE_VALID(SAMPLE_VALID),
  .STEP_TICK(STEP_TICK), .LIGHT_MEAS_DONE(LIGHT_MEAS_DONE),
  .FLICKER_STEP_DONE(FLICKER_STEP_DONE), .FLICKER_END_MARK(FLICKER_END_MARK),
  .IRQ_PIN(IRQ_PIN), .LIGHT_IRQ_FLAG(LIGHT_IRQ_FLAG), .LIGHT_LOW_IRQ_FLAG(LIGHT_LOW_IRQ_FLAG));

// [ls_timing_bench.sv]
// Self-checking bench of the light timing block
`timescale 1ns/1ps
module ls_timing_bench;
  reg         clk = 1'b0;
  reg         rst_b = 1'b0;
  reg         men = 1'b0, fen = 1'b0, ien = 1'b0, clr = 1'b0, vld = 1'b0, csel = 1'b1;
  reg  [2:0]  div = 3'h0;
  reg  [7:0]  unit = 8'h01;
  reg  [23:0] ch1 = 24'h0;
  wire [7:0]  addr, wdata, rdata;
  wire        wr, rd, tick, busy, ldone, fdone, fmark, irq, iflag, lflag;
  integer     mismatches = 0, checked = 0, n, i, k;
  reg  [7:0]  v;
  initial begin
    forever #5 clk = ~clk;
  end
  ls_host host (.CORE_CLK(clk), .REG_RDATA(rdata), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd));
  ls_timing dut (.CORE_CLK(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .MEAS_ENABLE(men), .FLICKER_ENABLE(fen),
    .MODULATOR_CLOCK_DIVIDER(div), .TRIGGER_TIMING_UNIT(unit), .LIMIT_CHANNEL_SELECT(csel),
    .PERSISTENCE_COUNT(4'h2), .LIGHT_IRQ_ENABLE(ien), .LIGHT_IRQ_FLAG_CLEAR(clr),
    .SAMPLE_VALID(vld), .CHANNEL0_DATA(24'hffffff), .CHANNEL1_DATA(ch1), .STEP_TICK(tick),
    .MEAS_BUSY(busy), .LIGHT_MEAS_DONE(ldone), .FLICKER_STEP_DONE(fdone),
    .FLICKER_END_MARK(fmark), .IRQ_PIN(irq), .LIGHT_IRQ_FLAG(iflag), .LIGHT_LOW_IRQ_FLAG(lflag));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: got %0h, expected %0h", $time, seen, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("checked %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Counts cycles up to a pulse: 0 step tick, 1 light done, 2 flicker done
  task wait_for(input integer sel, output integer cyc);
    begin
      cyc = 0;
      @(negedge clk);
      while ((sel == 0 ? tick : sel == 1 ? ldone : fdone) !== 1'b1) begin
        cyc = cyc + 1;
        if (cyc > 3000) begin
          mismatches = mismatches + 1;
          test_done;
        end
        @(negedge clk);
      end
    end
  endtask
  task t_regs;
    begin
      for (i = 8'h83; i <= 8'h8c; i = i + 1) begin
        host.rd(i, v);
        check(v, i == 8'h83 ? 8'hb3 : 8'h00);
      end
      for (i = 0; i < 3; i = i + 1) begin
        host.wr(8'h84 + 2 * i, 8'hff);
        host.rd(8'h84 + 2 * i, v);
        check(v, i == 2 ? 8'h87 : 8'h07);
        host.wr(8'h84 + 2 * i, 8'h00);
      end
      $display("register test done");
    end
  endtask
  // One step of one tick, two steps a measurement; divider doubles the tick
  task t_step(input [2:0] d);
    begin
      @(negedge clk) div = d;
      wait_for(1, n);
      wait_for(0, n);
      wait_for(0, n);
      check(n, (138 << d) - 1);
      wait_for(1, n);
      check(n, 0);
      $display("step test done");
    end
  endtask
  // A sequence only starts with a measurement start, so restart the measurement;
  // the second window must stay silent unless the endless bit is set
  task t_flicker(input endless);
    begin
      host.wr(8'h88, endless ? 8'h80 : 8'h00);
      @(negedge clk) men = 1'b0;
      @(negedge clk) men = 1'b1;
      for (i = 0; i < 2; i = i + 1) begin
        k = 0;
        for (n = 0; n < 600 && (n == 0 || fdone !== 1'b1); n = n + 1) begin
          @(negedge clk);
          k = k + (tick === 1'b1);
        end
        check({fdone, fmark}, {endless || i == 0, !endless && i == 0});
        if (fdone === 1'b1) check(k, 2);
      end
      $display("flicker test done");
    end
  endtask
  // Pause of unit times count ticks between two light measurements
  task t_pause;
    begin
      @(negedge clk) unit = 8'h03;
      host.wr(8'h89, 8'h02);
      wait_for(1, n);
      check(busy, 1);
      wait_for(1, n);
      check(n, (3 * 2 + 2) * 138 - 1);
      host.wr(8'h89, 8'h00);
      @(negedge clk) {men, fen} = 2'h0;
      @(negedge clk);
      @(negedge clk);
      check(busy, 0);
      $display("pause test done");
    end
  endtask
  task sample(input [23:0] d);
    begin
      @(negedge clk) {ch1, vld} = {d, 1'b1};
      @(negedge clk) vld = 1'b0;
      @(negedge clk);
    end
  endtask
  task t_irq;
    begin
      host.wr(8'h8b, 8'h01);
      ien = 1'b1;
      @(negedge clk) csel = 1'b0;
      sample(24'h0000ff);
      sample(24'h0000ff);
      check(irq, 0);
      @(negedge clk) csel = 1'b1;
      sample(24'h0000ff);
      sample(24'h000100);
      sample(24'h0000ff);
      check(irq, 0);
      sample(24'h0000ff);
      check({irq, iflag, lflag}, 3'h7);
      @(negedge clk) clr = 1'b1;
      @(negedge clk) clr = 1'b0;
      check({irq, iflag, lflag}, 3'h0);
      $display("interrupt test done");
    end
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    t_regs;
    host.wr(8'h83, 8'h00);
    host.wr(8'h85, 8'h01);
    host.wr(8'h87, 8'h01);
    @(negedge clk) {men, fen} = 2'h3;
    t_step(3'h0);
    t_step(3'h1);
    @(negedge clk) div = 3'h0;
    t_flicker(1'b0);
    t_flicker(1'b1);
    t_pause;
    t_irq;
    test_done;
  end
endmodule // ls_timing_bench
